// ===== logic/rtccal_top.v
// calibration, clock pin select and alarm configuration of the real time clock calendar
`timescale 1ns/10ps
`default_nettype none
`include "rtccal_defines.vh"
module rtccal_top #(
    parameter TICKS_PER_SEC = 32768,
    parameter CNT_W = 15
) (
    input wire clk,
    input wire arst_n,
    input wire por_arst_n,
    input wire low_power_rc_oscillator_clk_pin,
    input wire secondary_oscillator_clk_pin,
    input wire [`RTCCAL_ADDR_W-1:0] reg_addr,
    input wire [`RTCCAL_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`RTCCAL_DATA_W-1:0] reg_rdata_ff,
    output reg irq_ff,
    output reg clock_pin_out_ff,
    output reg clock_pin_oe_ff
);
    localparam [31:0] TOP_FULL = TICKS_PER_SEC - 1;
    localparam [31:0] HALF_FULL = TICKS_PER_SEC / 2;
    localparam [CNT_W-1:0] PRESC_TOP = TOP_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] PRESC_HALF = HALF_FULL[CNT_W-1:0];

    // calibration and configuration state (power-on reset only)
    reg module_enable_bit_ff;
    reg value_write_unlock_ff;
    reg out_enable_ff;
    reg [1:0] value_ptr_ff;
    reg [7:0] cal_ff;
    // pad configuration and own control
    reg twowire_input_delay_select_ff;
    reg compare_output_tristate_ff;
    reg [1:0] clock_pin_output_select_ff;
    reg timebase_source_select_ff;
    // alarm configuration
    reg alarm_enable_bit_ff;
    reg alarm_rollover_repeat_ff;
    reg [3:0] alarm_interval_mask_ff;
    reg [1:0] alarm_window_pointer_ff;
    reg [7:0] alarm_repeat_count_ff;
    reg [7:0] alm_val_ff [0:5];
    reg alarm_pulse_ff;
    // timebase and time of day
    reg src_prev_ff;
    reg [CNT_W-1:0] presc_ff;
    reg [3:0] sec_one_ff;
    reg [2:0] sec_ten_ff;
    reg [3:0] min_one_ff;
    reg [2:0] min_ten_ff;
    reg sec_tick_d_ff;
    reg half_tick_d_ff;
    reg [`RTCCAL_IRQ_W-1:0] irq_stat_ff;
    reg [`RTCCAL_IRQ_W-1:0] irq_mask_ff;

    wire [1:0] pins_sync;
    wire adj_tick;
    wire src_clk;
    wire raw_tick;
    wire sec_tick;
    wire half_tick;
    wire minute_pulse;
    wire half_second_flag;
    wire wr_cal;
    wire wr_pad;
    wire wr_acfg;
    wire wr_minutes_seconds_value;
    wire win_access;
    wire ptr_valid;
    wire [2:0] idx_lo;
    wire [2:0] idx_hi;
    reg alarm_hit;
    reg [`RTCCAL_IRQ_W-1:0] nxt_irq_stat;
    reg nxt_pin;
    reg [`RTCCAL_DATA_W-1:0] nxt_rdata;
    integer i;

    // oscillator pins are asynchronous to clk
    rtccal_sync #(.W(2)) u_pin_sync (
        .clk(clk),
        .arst_n(arst_n),
        .async_in({secondary_oscillator_clk_pin, low_power_rc_oscillator_clk_pin}),
        .sync_ff(pins_sync)
    );

    assign src_clk = timebase_source_select_ff ? pins_sync[1] : pins_sync[0];
    assign raw_tick = src_clk & ~src_prev_ff & module_enable_bit_ff;

    rtccal_drift u_drift (
        .clk(clk),
        .arst_n(arst_n),
        .raw_tick(raw_tick),
        .minute_pulse(minute_pulse),
        .cal(cal_ff),
        .adj_tick_ff(adj_tick)
    );

    // register port decode
    assign wr_cal = reg_wr && (reg_addr == `RTCCAL_ADDR_CAL);
    assign wr_pad = reg_wr && (reg_addr == `RTCCAL_ADDR_PAD);
    assign wr_acfg = reg_wr && (reg_addr == `RTCCAL_ADDR_ACFG);
    assign wr_minutes_seconds_value = reg_wr && (reg_addr == `RTCCAL_ADDR_MINUTES_SECONDS_VALUE);
    assign win_access = (reg_wr || reg_rd) && (reg_addr == `RTCCAL_ADDR_AWIN);
    assign ptr_valid = (alarm_window_pointer_ff != `RTCCAL_PTR_NONE);
    assign idx_lo = {1'b0, alarm_window_pointer_ff};
    assign idx_hi = idx_lo + `RTCCAL_WIN_HI_BASE;

    assign sec_tick = adj_tick && (presc_ff == PRESC_TOP);
    assign half_tick = adj_tick && (presc_ff == PRESC_HALF - 1'b1);
    assign minute_pulse = sec_tick && (sec_ten_ff == `RTCCAL_BCD_FIVE) && (sec_one_ff == `RTCCAL_BCD_NINE);
    assign half_second_flag = (presc_ff >= PRESC_HALF);

    // only the power-on reset clears this group; arst_n leaves it alone
    always @(posedge clk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            module_enable_bit_ff <= 1'b0;
            value_write_unlock_ff <= 1'b0;
            out_enable_ff <= 1'b0;
            value_ptr_ff <= `RTCCAL_RST_PTR;
            cal_ff <= `RTCCAL_RST_BYTE;
        end else if (wr_cal) begin
            if (value_write_unlock_ff) begin
                module_enable_bit_ff <= reg_wdata[`RTCCAL_CAL_EN];
            end
            value_write_unlock_ff <= reg_wdata[`RTCCAL_CAL_UNLOCK];
            out_enable_ff <= reg_wdata[`RTCCAL_CAL_OE];
            value_ptr_ff <= reg_wdata[`RTCCAL_CAL_VPTR];
            cal_ff <= reg_wdata[`RTCCAL_CAL_DRIFT];
        end
    end

    // pad configuration and timebase source select
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            twowire_input_delay_select_ff <= 1'b0;
            compare_output_tristate_ff <= 1'b0;
            clock_pin_output_select_ff <= `RTCCAL_OSEL_ALARM;
            timebase_source_select_ff <= 1'b0;
        end else begin
            if (wr_pad) begin
                twowire_input_delay_select_ff <= reg_wdata[`RTCCAL_PAD_TWDEL];
                compare_output_tristate_ff <= reg_wdata[`RTCCAL_PAD_OCTRIS];
                clock_pin_output_select_ff <= reg_wdata[`RTCCAL_PAD_SEL];
            end
            if (reg_wr && (reg_addr == `RTCCAL_ADDR_TBCTL)) begin
                timebase_source_select_ff <= reg_wdata[0];
            end
        end
    end

    // prescaler and bcd minutes/seconds; a software load wins over a tick
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_prev_ff <= 1'b0;
            presc_ff <= {CNT_W{1'b0}};
            sec_one_ff <= 4'h0;
            sec_ten_ff <= 3'h0;
            min_one_ff <= 4'h0;
            min_ten_ff <= 3'h0;
            sec_tick_d_ff <= 1'b0;
            half_tick_d_ff <= 1'b0;
        end else begin
            src_prev_ff <= src_clk;
            sec_tick_d_ff <= sec_tick;
            half_tick_d_ff <= half_tick;
            if (wr_minutes_seconds_value) begin
                presc_ff <= {CNT_W{1'b0}}; // restart second clears the half flag
            end else if (sec_tick) begin
                presc_ff <= {CNT_W{1'b0}};
            end else if (adj_tick) begin
                presc_ff <= presc_ff + 1'b1;
            end
            if (wr_minutes_seconds_value && value_write_unlock_ff) begin
                sec_one_ff <= reg_wdata[3:0];
                sec_ten_ff <= reg_wdata[6:4];
                min_one_ff <= reg_wdata[11:8];
                min_ten_ff <= reg_wdata[14:12];
            end else if (sec_tick) begin
                if (sec_one_ff != `RTCCAL_BCD_NINE) begin
                    sec_one_ff <= sec_one_ff + 1'b1;
                end else begin
                    sec_one_ff <= 4'h0;
                    sec_ten_ff <= (sec_ten_ff == `RTCCAL_BCD_FIVE) ? 3'h0 : sec_ten_ff + 1'b1;
                    if (sec_ten_ff == `RTCCAL_BCD_FIVE) begin
                        min_one_ff <= (min_one_ff == `RTCCAL_BCD_NINE) ? 4'h0 : min_one_ff + 1'b1;
                        if (min_one_ff == `RTCCAL_BCD_NINE) begin
                            min_ten_ff <= (min_ten_ff == `RTCCAL_BCD_FIVE) ? 3'h0 : min_ten_ff + 1'b1;
                        end
                    end
                end
            end
        end
    end

    // alarm match, judged one cycle after the tick so the counters already hold the new time;
    // interval codes 5 to 9 only compare minutes and seconds, as hours are not kept here; codes above 9 never match
    always @* begin
        alarm_hit = 1'b0;
        case (alarm_interval_mask_ff)
            `RTCCAL_AM_HALF_SECOND_FLAG: alarm_hit = sec_tick_d_ff | half_tick_d_ff;
            `RTCCAL_AM_SEC: alarm_hit = sec_tick_d_ff;
            `RTCCAL_AM_10SEC: alarm_hit = sec_tick_d_ff && (sec_one_ff == 4'h0);
            `RTCCAL_AM_MIN: alarm_hit = sec_tick_d_ff && ({sec_ten_ff, sec_one_ff} == 7'h00);
            `RTCCAL_AM_10MIN: alarm_hit = sec_tick_d_ff && ({min_one_ff, sec_ten_ff, sec_one_ff} == 11'h000);
            default: begin
                if (alarm_interval_mask_ff <= `RTCCAL_AM_LAST) begin
                    alarm_hit = sec_tick_d_ff
                        && ({1'b0, sec_ten_ff, sec_one_ff} == alm_val_ff[`RTCCAL_ALM_SEC])
                        && ({1'b0, min_ten_ff, min_one_ff} == alm_val_ff[`RTCCAL_ALM_MIN]);
                end
            end
        endcase
    end

    // alarm configuration, window pointer, repeat count and alarm values
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_enable_bit_ff <= 1'b0;
            alarm_rollover_repeat_ff <= 1'b0;
            alarm_interval_mask_ff <= `RTCCAL_RST_MASK;
            alarm_window_pointer_ff <= `RTCCAL_RST_PTR;
            alarm_repeat_count_ff <= `RTCCAL_RST_BYTE;
            alarm_pulse_ff <= 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                alm_val_ff[i] <= `RTCCAL_RST_BYTE;
            end
        end else if (wr_acfg) begin
            alarm_enable_bit_ff <= reg_wdata[`RTCCAL_ACFG_EN];
            alarm_rollover_repeat_ff <= reg_wdata[`RTCCAL_ACFG_ALARM_ROLLOVER_REPEAT];
            alarm_interval_mask_ff <= reg_wdata[`RTCCAL_ACFG_MASK];
            alarm_window_pointer_ff <= reg_wdata[`RTCCAL_ACFG_PTR];
            alarm_repeat_count_ff <= reg_wdata[`RTCCAL_ACFG_RPT];
        end else begin
            if (win_access) begin
                if (reg_wr && ptr_valid) begin
                    alm_val_ff[idx_hi] <= reg_wdata[`RTCCAL_HI];
                    alm_val_ff[idx_lo] <= reg_wdata[`RTCCAL_LO];
                end
                if (alarm_window_pointer_ff != `RTCCAL_RST_PTR) begin
                    alarm_window_pointer_ff <= alarm_window_pointer_ff - 1'b1;
                end
            end
            if (alarm_enable_bit_ff && alarm_hit) begin
                alarm_pulse_ff <= ~alarm_pulse_ff;
                alarm_repeat_count_ff <= alarm_repeat_count_ff - 1'b1; // wraps to ff under rollover
                if (alarm_repeat_count_ff == `RTCCAL_RST_BYTE && !alarm_rollover_repeat_ff) begin
                    alarm_enable_bit_ff <= 1'b0; // last repeat done
                    alarm_repeat_count_ff <= `RTCCAL_RST_BYTE;
                end
            end
        end
    end

    // sticky status: an event in the clearing cycle survives the write-one-to-clear
    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (reg_wr && (reg_addr == `RTCCAL_ADDR_ISTAT)) begin
            nxt_irq_stat = irq_stat_ff & ~reg_wdata[`RTCCAL_IRQ_W-1:0];
        end
        nxt_irq_stat[`RTCCAL_IRQ_ALARM] = nxt_irq_stat[`RTCCAL_IRQ_ALARM] | (alarm_enable_bit_ff & alarm_hit);
        nxt_irq_stat[`RTCCAL_IRQ_SEC] = nxt_irq_stat[`RTCCAL_IRQ_SEC] | sec_tick;
        nxt_irq_stat[`RTCCAL_IRQ_MIN] = nxt_irq_stat[`RTCCAL_IRQ_MIN] | minute_pulse;
    end

    // clock pin source select; reserved code drives low
    always @* begin
        case (clock_pin_output_select_ff)
            `RTCCAL_OSEL_ALARM: nxt_pin = alarm_pulse_ff;
            `RTCCAL_OSEL_SECS: nxt_pin = ~half_second_flag;
            `RTCCAL_OSEL_SRC: nxt_pin = src_clk;
            default: nxt_pin = 1'b0;
        endcase
    end

    // read mux; unimplemented bits are zero
    always @* begin
        nxt_rdata = `RTCCAL_RST_WORD;
        case (reg_addr)
            `RTCCAL_ADDR_CAL: begin
                nxt_rdata[`RTCCAL_CAL_EN] = module_enable_bit_ff;
                nxt_rdata[`RTCCAL_CAL_UNLOCK] = value_write_unlock_ff;
                nxt_rdata[`RTCCAL_CAL_HALF] = half_second_flag;
                nxt_rdata[`RTCCAL_CAL_OE] = out_enable_ff;
                nxt_rdata[`RTCCAL_CAL_VPTR] = value_ptr_ff;
                nxt_rdata[`RTCCAL_CAL_DRIFT] = cal_ff;
            end
            `RTCCAL_ADDR_PAD: begin
                nxt_rdata[`RTCCAL_PAD_TWDEL] = twowire_input_delay_select_ff;
                nxt_rdata[`RTCCAL_PAD_OCTRIS] = compare_output_tristate_ff;
                nxt_rdata[`RTCCAL_PAD_SEL] = clock_pin_output_select_ff;
            end
            `RTCCAL_ADDR_ACFG: begin
                nxt_rdata = {alarm_enable_bit_ff, alarm_rollover_repeat_ff, alarm_interval_mask_ff,
                             alarm_window_pointer_ff, alarm_repeat_count_ff};
            end
            `RTCCAL_ADDR_AWIN: begin
                if (ptr_valid) begin
                    nxt_rdata = {alm_val_ff[idx_hi], alm_val_ff[idx_lo]};
                end
            end
            `RTCCAL_ADDR_MINUTES_SECONDS_VALUE: nxt_rdata = {1'b0, min_ten_ff, min_one_ff, 1'b0, sec_ten_ff, sec_one_ff};
            `RTCCAL_ADDR_ISTAT: nxt_rdata[`RTCCAL_IRQ_W-1:0] = irq_stat_ff;
            `RTCCAL_ADDR_IMASK: nxt_rdata[`RTCCAL_IRQ_W-1:0] = irq_mask_ff;
            `RTCCAL_ADDR_TBCTL: nxt_rdata[0] = timebase_source_select_ff;
            default: nxt_rdata = `RTCCAL_RST_WORD;
        endcase
    end

    // output registers, interrupt status and mask
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= `RTCCAL_RST_IRQ;
            irq_mask_ff <= `RTCCAL_RST_IRQ;
            irq_ff <= 1'b0;
            reg_rdata_ff <= `RTCCAL_RST_WORD;
            clock_pin_out_ff <= 1'b0;
            clock_pin_oe_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (reg_wr && (reg_addr == `RTCCAL_ADDR_IMASK)) begin
                irq_mask_ff <= reg_wdata[`RTCCAL_IRQ_W-1:0];
            end
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
            reg_rdata_ff <= reg_rd ? nxt_rdata : `RTCCAL_RST_WORD;
            clock_pin_out_ff <= out_enable_ff & module_enable_bit_ff & nxt_pin;
            clock_pin_oe_ff <= out_enable_ff & module_enable_bit_ff;
        end
    end
endmodule // rtccal_top
`default_nettype wire

// ===== logic/rtccal_defines.vh
// register map, field positions and reset values of the clock calibration and alarm block
`ifndef RTCCAL_DEFINES_VH
`define RTCCAL_DEFINES_VH

// register indices on the plain register port
`define RTCCAL_ADDR_W 4
`define RTCCAL_DATA_W 16
`define RTCCAL_ADDR_CAL 4'h0
`define RTCCAL_ADDR_PAD 4'h1
`define RTCCAL_ADDR_ACFG 4'h2
`define RTCCAL_ADDR_AWIN 4'h3
`define RTCCAL_ADDR_MINUTES_SECONDS_VALUE 4'h4
`define RTCCAL_ADDR_ISTAT 4'h5
`define RTCCAL_ADDR_IMASK 4'h6
`define RTCCAL_ADDR_TBCTL 4'h7

// rtc_calibration_config fields
`define RTCCAL_CAL_EN 15
`define RTCCAL_CAL_UNLOCK 13
`define RTCCAL_CAL_HALF 11
`define RTCCAL_CAL_OE 10
`define RTCCAL_CAL_VPTR 9:8
`define RTCCAL_CAL_DRIFT 7:0
`define RTCCAL_CAL_SIGN 7

// pad_configuration fields
`define RTCCAL_PAD_TWDEL 4
`define RTCCAL_PAD_OCTRIS 3
`define RTCCAL_PAD_SEL 2:1

// alarm_config_repeat fields
`define RTCCAL_ACFG_EN 15
`define RTCCAL_ACFG_ALARM_ROLLOVER_REPEAT 14
`define RTCCAL_ACFG_MASK 13:10
`define RTCCAL_ACFG_PTR 9:8
`define RTCCAL_ACFG_RPT 7:0

// byte halves of 16-bit words
`define RTCCAL_HI 15:8
`define RTCCAL_LO 7:0

// clock pin output select codes
`define RTCCAL_OSEL_ALARM 2'b00
`define RTCCAL_OSEL_SECS 2'b01
`define RTCCAL_OSEL_SRC 2'b10

// alarm interval mask codes
`define RTCCAL_AM_HALF_SECOND_FLAG 4'h0
`define RTCCAL_AM_SEC 4'h1
`define RTCCAL_AM_10SEC 4'h2
`define RTCCAL_AM_MIN 4'h3
`define RTCCAL_AM_10MIN 4'h4
`define RTCCAL_AM_LAST 4'h9

// interrupt status bits
`define RTCCAL_IRQ_W 3
`define RTCCAL_IRQ_ALARM 0
`define RTCCAL_IRQ_SEC 1
`define RTCCAL_IRQ_MIN 2

// reset values
`define RTCCAL_RST_BYTE 8'h00
`define RTCCAL_RST_PTR 2'b00
`define RTCCAL_RST_MASK 4'h0
`define RTCCAL_RST_IRQ 3'h0
`define RTCCAL_RST_WORD 16'h0000

// calibration: each code step is four timebase pulses
`define RTCCAL_STEP_SHIFT 2
`define RTCCAL_ADJ_W 10

// bcd limits and alarm window layout
`define RTCCAL_BCD_NINE 4'h9
`define RTCCAL_BCD_FIVE 3'h5
`define RTCCAL_PTR_NONE 2'b11
`define RTCCAL_WIN_HI_BASE 3'h3
`define RTCCAL_ALM_SEC 0
`define RTCCAL_ALM_MIN 3

`endif

// ===== logic/rtccal_sync.v
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module rtccal_sync #(
    parameter W = 2
) (
    input wire clk,
    input wire arst_n,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_ff
);
    reg [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
endmodule // rtccal_sync
`default_nettype wire

// ===== logic/rtccal_drift.v
// drift calibration: inserts or swallows timebase pulses once per minute
`timescale 1ns/10ps
`default_nettype none
`include "rtccal_defines.vh"
module rtccal_drift (
    input wire clk,
    input wire arst_n,
    input wire raw_tick,
    input wire minute_pulse,
    input wire [7:0] cal,
    output reg adj_tick_ff
);
    reg [`RTCCAL_ADJ_W-1:0] pending_ff;
    reg neg_ff;
    wire [7:0] mag;
    wire [`RTCCAL_ADJ_W-1:0] load_val;

    // two's complement magnitude; 8'h80 gives 128, so 512 pulses fit in ten bits
    assign mag = cal[`RTCCAL_CAL_SIGN] ? (~cal + 8'h01) : cal;
    assign load_val = {mag, {`RTCCAL_STEP_SHIFT{1'b0}}};

    // an extra pulse is slotted into an idle cycle; raw ticks are far slower than clk
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_ff <= {`RTCCAL_ADJ_W{1'b0}};
            neg_ff <= 1'b0;
            adj_tick_ff <= 1'b0;
        end else if (minute_pulse) begin
            pending_ff <= load_val;
            neg_ff <= cal[`RTCCAL_CAL_SIGN];
            adj_tick_ff <= raw_tick;
        end else if (pending_ff != {`RTCCAL_ADJ_W{1'b0}} && neg_ff && raw_tick) begin
            pending_ff <= pending_ff - 1'b1; // swallow one pulse
            adj_tick_ff <= 1'b0;
        end else if (pending_ff != {`RTCCAL_ADJ_W{1'b0}} && !neg_ff && !raw_tick) begin
            pending_ff <= pending_ff - 1'b1; // insert one pulse
            adj_tick_ff <= 1'b1;
        end else begin
            adj_tick_ff <= raw_tick;
        end
    end
endmodule // rtccal_drift
`default_nettype wire

// ===== testbench/rtccal_top_assertions.sv
// port checker of the calibration, clock pin and alarm block
`timescale 1ns/10ps
`default_nettype none
module rtccal_top_assertions (
    input wire clk,
    input wire arst_n,
    input wire por_arst_n,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata_ff,
    input wire irq_ff,
    input wire clock_pin_out_ff,
    input wire clock_pin_oe_ff
);
    logic en_ff, unl_ff, oen_ff;
    logic [7:0] cal_ff;
    logic [1:0] sel_ff;
    logic [2:0] msk_ff;
    wire cal_wr = reg_wr && reg_addr == 4'h0;
    // shadow of the power-on register; the plain reset must not touch it
    always @(posedge clk or negedge por_arst_n) begin
        if (!por_arst_n) begin
            {en_ff, unl_ff, oen_ff, cal_ff} <= 11'h000;
        end else if (cal_wr) begin
            en_ff <= unl_ff ? reg_wdata[15] : en_ff;
            {unl_ff, oen_ff, cal_ff} <= {reg_wdata[13], reg_wdata[10], reg_wdata[7:0]};
        end
    end
    // shadows of pin select and interrupt mask
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {sel_ff, msk_ff} <= 5'h00;
        end else begin
            sel_ff <= (reg_wr && reg_addr == 4'h1) ? reg_wdata[2:1] : sel_ff;
            msk_ff <= (reg_wr && reg_addr == 4'h6) ? reg_wdata[2:0] : msk_ff;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n || !por_arst_n);
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
        else $error("read data not zero outside a read");
    a_pad_unused_zero: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata_ff[15:5] == 11'h000 && !reg_rdata_ff[0])
        else $error("unused pad bits read nonzero");
    a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata_ff == 16'h0000)
        else $error("unmapped index read nonzero");
    a_cal_readback: assert property (reg_rd && reg_addr == 4'h0 |=>
        {reg_rdata_ff[15], reg_rdata_ff[13], reg_rdata_ff[10], reg_rdata_ff[7:0]} == {en_ff, unl_ff, oen_ff, cal_ff})
        else $error("calibration register readback wrong");
    a_half_write_clear: assert property (reg_wr && reg_addr == 4'h4 ##2 reg_rd && reg_addr == 4'h0 |=> !reg_rdata_ff[11])
        else $error("half flag not cleared by minutes write");
    a_irq_masked_off: assert property ((msk_ff == 3'h0)[*3] |-> !irq_ff)
        else $error("interrupt high with all sources masked");
    a_oe_pin_on: assert property ((en_ff && oen_ff)[*3] |-> clock_pin_oe_ff)
        else $error("pin not driven while enabled");
    a_oe_pin_off: assert property ((!(en_ff && oen_ff))[*3] |-> !clock_pin_oe_ff)
        else $error("pin driven while disabled");
    a_sel_reserved_low: assert property ((sel_ff == 2'b11)[*3] |-> !clock_pin_out_ff)
        else $error("reserved select drives pin high");
    c_cal_unlocked: cover property (cal_wr && unl_ff);
    c_irq_rise: cover property ($rose(irq_ff));
    c_pad_read: cover property (reg_rd && reg_addr == 4'h1);
endmodule // rtccal_top_assertions
`default_nettype wire

// ===== testbench/rtccal_top_test.sv
// self-checking bench of the calibration, clock pin and alarm block
`timescale 1ns/10ps
`default_nettype none
module rtccal_top_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic por_arst_n = 1'b0;
    logic low_power_rc_oscillator = 1'b0;
    logic secondary_oscillator = 1'b0;
    logic run = 1'b1;
    logic low_power_rc_oscillator_hold = 1'b0;
    logic [1:0] div = 2'b00;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    wire [15:0] rdata;
    wire irq, pin, pin_oe;
    int err_count = 0;
    int n_compared = 0;
    longint t0;
    int d;
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'hff, 8'h7f, 8'h80};
    rtccal_top #(.TICKS_PER_SEC(16), .CNT_W(5)) u_rtccal_top (.clk(clk), .arst_n(arst_n), .por_arst_n(por_arst_n),
        .low_power_rc_oscillator_clk_pin(low_power_rc_oscillator), .secondary_oscillator_clk_pin(secondary_oscillator), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata_ff(rdata), .irq_ff(irq), .clock_pin_out_ff(pin), .clock_pin_oe_ff(pin_oe));
    initial forever #4 clk = ~clk;
    // rc timebase at one eighth of the bus clock, so a second is 128 cycles
    always @(posedge clk) begin
        div <= div + 2'd1;
        if (!run) low_power_rc_oscillator <= low_power_rc_oscillator_hold;
        else if (div == 2'd3) low_power_rc_oscillator <= ~low_power_rc_oscillator;
    end
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, exp);
    endtask
    // bounded wait for the interrupt level; running out ends the run
    task automatic wait_irq(input logic v);
        int n;
        n = 0;
        while (irq !== v && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (irq !== v) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, irq, v);
            final_report;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        por_arst_n <= 1'b1;
        rdc(4'h0, 16'hffff, 16'h0000);
        wrr(4'h0, 16'h8400);
        rdc(4'h0, 16'hffff, 16'h0400);
        wrr(4'h0, 16'h2400);
        wrr(4'h0, 16'ha400);
        rdc(4'h0, 16'hf7ff, 16'ha400);
        wrr(4'h1, 16'hffff);
        rdc(4'h1, 16'hffff, 16'h001e);
        rdc(4'h9, 16'hffff, 16'h0000);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdc(4'h0, 16'hf7ff, 16'ha400);
        rdc(4'h1, 16'hffff, 16'h0000);
        $display("test reset and protection done");
        run <= 1'b0;
        wrr(4'h1, 16'h0004);
        low_power_rc_oscillator_hold <= 1'b1;
        repeat (6) @(posedge clk);
        chk({15'h0000, pin}, 16'h0001);
        chk({15'h0000, pin_oe}, 16'h0001);
        wrr(4'h7, 16'h0001);
        repeat (6) @(posedge clk);
        chk({15'h0000, pin}, 16'h0000);
        secondary_oscillator <= 1'b1;
        repeat (6) @(posedge clk);
        chk({15'h0000, pin}, 16'h0001);
        wrr(4'h7, 16'h0000);
        run <= 1'b1;
        wrr(4'h1, 16'h0002);
        wrr(4'h4, 16'h0530);
        rdc(4'h4, 16'hffff, 16'h0530);
        rdc(4'h0, 16'h0800, 16'h0000);
        chk({15'h0000, pin}, 16'h0001);
        repeat (100) @(posedge clk);
        rdc(4'h0, 16'h0800, 16'h0800);
        chk({15'h0000, pin}, 16'h0000);
        wrr(4'h4, 16'h0530);
        rdc(4'h0, 16'h0800, 16'h0000);
        wrr(4'h0, 16'h8400);
        wrr(4'h4, 16'h1111);
        rdc(4'h4, 16'hffff, 16'h0530);
        wrr(4'h0, 16'ha400);
        $display("test pin and time lock done");
        wrr(4'h2, 16'h0200);
        wrr(4'h3, 16'h1231);
        wrr(4'h3, 16'h0623);
        wrr(4'h3, 16'h5945);
        rdc(4'h2, 16'h0300, 16'h0000);
        wrr(4'h2, 16'h0200);
        rdc(4'h3, 16'hffff, 16'h1231);
        rdc(4'h3, 16'hffff, 16'h0623);
        rdc(4'h3, 16'hffff, 16'h5945);
        rdc(4'h3, 16'hffff, 16'h5945);
        wrr(4'h2, 16'h0300);
        rdc(4'h3, 16'hffff, 16'h0000);
        $display("test alarm window done");
        wrr(4'h6, 16'h0000);
        repeat (150) @(posedge clk);
        rdc(4'h5, 16'h0002, 16'h0002);
        chk({15'h0000, irq}, 16'h0000);
        wrr(4'h6, 16'h0002);
        wait_irq(1'b1);
        wrr(4'h6, 16'h0000);
        wait_irq(1'b0);
        wrr(4'h5, 16'h0007);
        rdc(4'h5, 16'h0007, 16'h0000);
        $display("test interrupt done");
        // alarm every second with one repeat: two events, then the enable drops
        wrr(4'h1, 16'h0000);
        wrr(4'h5, 16'h0007);
        wrr(4'h6, 16'h0001);
        wrr(4'h2, 16'h8401);
        wait_irq(1'b1);
        wrr(4'h5, 16'h0001);
        rdc(4'h2, 16'h80ff, 16'h8000);
        chk({15'h0000, pin}, 16'h0001);
        wait_irq(1'b1);
        rdc(4'h2, 16'h80ff, 16'h0000);
        chk({15'h0000, pin}, 16'h0000);
        $display("test alarm repeat done");
        // minute length in bus cycles shrinks or grows by eight per moved pulse
        wrr(4'h6, 16'h0004);
        wrr(4'h0, {8'ha4, codes[0]});
        wait_irq(1'b1);
        for (int i = 0; i < 5; i++) begin
            t0 = $time;
            wrr(4'h5, 16'h0004);
            wrr(4'h0, {8'ha4, codes[(i + 1) % 5]});
            wait_irq(1'b1);
            d = int'(($time - t0) / 8) - (960 - 4 * int'($signed(codes[i]))) * 8;
            n_compared++;
            if (d > 24 || d < -24) begin
                err_count++;
                $display("BAD t=%0t got=%h exp=%h", $time, d, 0);
            end
        end
        $display("test calibration done");
        final_report;
    end
endmodule // rtccal_top_test
bind rtccal_top rtccal_top_assertions u_rtccal_top_assertions (.clk(clk), .arst_n(arst_n), .por_arst_n(por_arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .irq_ff(irq_ff), .clock_pin_out_ff(clock_pin_out_ff), .clock_pin_oe_ff(clock_pin_oe_ff));
`default_nettype wire
